// >>> lss_pkg.sv
// Purpose: Shared constants and types for the secondary loader status register.
// Assumes: Byte-wide command codes delivered by the loader's serial command handler.
// Notes: Bit positions refer to the 8-bit secondary status byte.
package lss_pkg;

    // Command codes seen by the command handler.
    localparam logic [7:0] LSS_CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] LSS_CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] LSS_CMD_PAGE_READ = 8'hFF;
    localparam logic [7:0] LSS_CMD_PAGE_PROGRAM = 8'h41;
    localparam logic [7:0] LSS_CMD_ERASE_ALL = 8'hA7;
    localparam logic [7:0] LSS_CMD_DOWNLOAD = 8'hFA;
    localparam logic [7:0] LSS_CMD_VERSION = 8'hFB;
    localparam logic [7:0] LSS_CMD_ID_CHECK = 8'hF5;

    // Field positions in the secondary status byte.
    localparam int LSS_BIT_BOOT_DONE = 7;
    localparam int LSS_BIT_CHECKSUM = 4;
    localparam int LSS_BIT_ID_HIGH = 3;
    localparam int LSS_BIT_ID_LOW = 2;
    localparam int LSS_BIT_RX_TIMEOUT = 1;

    // Power-on value of the register.
    localparam logic [7:0] LSS_POWER_ON_VALUE = 8'h00;

    // ID-check result codes.
    localparam logic [1:0] LSS_ID_NOT_VERIFIED = 2'h0;
    localparam logic [1:0] LSS_ID_MISMATCH = 2'h1;
    localparam logic [1:0] LSS_ID_VERIFIED = 2'h3;

    typedef enum logic [2:0] {
        LSS_ST_IDLE = 3'h1,
        LSS_ST_SEND_PRIMARY = 3'h2,
        LSS_ST_SEND_SECONDARY = 3'h4
    } lss_state_t;

endpackage : lss_pkg

// >>> lss_status_reg.sv
// Purpose: Secondary status register of the flash boot loader in serial programming mode.
// Assumes: Command bytes, loader events and the primary status byte come from the loader core.
// Notes: Of the two resets only power_on clears the flags; reset leaves them as they were.
//
// Contract
// - Bits 3 and 2 hold the ID-check result, 00 not verified, 01 mismatch, 11 verified.
// - Protected loader commands are refused until the ID-check result reads verified.
// - Bit 1 is set when a timeout occurs during data reception and stays set until a clear-status command or power-on.
// - A reception timeout discards the partial data and returns the handler to command wait.
// - Bit 7 reads one once a loader program has been downloaded into RAM.
// - Bit 4 shows whether the download checksum matched the sum of the program bytes.
// - A read-status command returns the primary status byte and then this register.
// - A clear-status command clears this register.
// - The register is zero after power-on and keeps its flags through a later reset.
`timescale 1ns/1ns

module lss_status_reg (
    // Clock and resets
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic power_on,
    // Command from the serial command handler
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    // Loader events
    input wire logic rx_active,
    input wire logic rx_timeout,
    input wire logic download_end,
    input wire logic checksum_ok,
    input wire logic id_check_end,
    input wire logic id_match,
    // Primary status byte supplied by the neighbouring register
    input wire logic [7:0] primary_status,
    // Answer stream towards the serial transmitter
    output logic tx_valid,
    output logic [7:0] tx_data,
    // Command handler control
    output logic cmd_accept,
    output logic cmd_reject,
    output logic rx_discard,
    // Register view
    output logic [7:0] loader_status_secondary,
    output logic id_verified
);
    import lss_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        // Flag storage; of the two resets only power_on clears it, reset leaves it alone.
        logic boot_update_done_flag;
        logic checksum_match_flag;
        logic id_result_high_bit;
        logic id_result_low_bit;
        logic rx_timeout_flag;
        // Answer sequencer and the primary byte that it sends first.
        lss_state_t state;
        logic [7:0] primary_latch;
        // Registered copies of the handler outputs.
        logic tx_valid;
        logic [7:0] tx_data;
        logic cmd_accept;
        logic cmd_reject;
        logic rx_discard;
        // Register view and verified level, kept in step with the flags above.
        logic [7:0] status_view;
        logic id_verified;
    } lss_regs_t;

    // Every flip-flop of the block lives in r; next_r is its combinational next value.
    lss_regs_t r;
    lss_regs_t next_r;

    // Commands that touch flash or RAM are locked until the ID code has matched.
    function automatic logic lss_needs_id(input logic [7:0] code);
        lss_needs_id = (code == LSS_CMD_PAGE_READ) || (code == LSS_CMD_PAGE_PROGRAM) ||
                       (code == LSS_CMD_ERASE_ALL) || (code == LSS_CMD_DOWNLOAD);
    endfunction

    // Reserved bits are forced to zero whatever the flag storage holds.
    function automatic logic [7:0] lss_compose(input lss_regs_t s);
        logic [7:0] b;
        b = LSS_POWER_ON_VALUE;
        b[LSS_BIT_BOOT_DONE] = s.boot_update_done_flag;
        b[LSS_BIT_CHECKSUM] = s.checksum_match_flag;
        b[LSS_BIT_ID_HIGH] = s.id_result_high_bit;
        b[LSS_BIT_ID_LOW] = s.id_result_low_bit;
        b[LSS_BIT_RX_TIMEOUT] = s.rx_timeout_flag;
        lss_compose = b;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////

    // Decodes of the current inputs, shared by the flag logic and the answer sequencer.
    logic is_clear;
    logic is_read;
    logic verified_now;
    logic timeout_hit;

    // Priority, lowest first: command decode, loader events, then reset and power_on.
    // Events are applied after the clear so that a flag raised in the same cycle as a
    // clear-status command is not lost; the programmer sees it on its next status poll.
    // The reset branch restores the flags from r, so an event that coincides with reset
    // is dropped; the loader core is not expected to raise events while held in reset.
    always_comb begin
        next_r = r;
        is_clear = cmd_valid && (cmd_code == LSS_CMD_CLEAR_STATUS);
        is_read = cmd_valid && (cmd_code == LSS_CMD_READ_STATUS);
        verified_now = {r.id_result_high_bit, r.id_result_low_bit} == LSS_ID_VERIFIED;
        timeout_hit = rx_timeout && rx_active;
        next_r.tx_valid = 1'b0;
        next_r.cmd_accept = 1'b0;
        next_r.cmd_reject = 1'b0;
        next_r.rx_discard = 1'b0;

        // Clearing comes first so that an event in the same cycle overrides it.
        if (is_clear) begin
            next_r.boot_update_done_flag = 1'b0;
            next_r.checksum_match_flag = 1'b0;
            next_r.id_result_high_bit = LSS_ID_NOT_VERIFIED[1];
            next_r.id_result_low_bit = LSS_ID_NOT_VERIFIED[0];
            next_r.rx_timeout_flag = 1'b0;
        end
        // Each event writes only its own field, so any mix of them may share a cycle.
        if (download_end) begin
            next_r.boot_update_done_flag = 1'b1;
            next_r.checksum_match_flag = checksum_ok;
        end
        if (id_check_end) begin
            next_r.id_result_high_bit = id_match ? LSS_ID_VERIFIED[1] : LSS_ID_MISMATCH[1];
            next_r.id_result_low_bit = id_match ? LSS_ID_VERIFIED[0] : LSS_ID_MISMATCH[0];
        end
        if (timeout_hit) begin
            next_r.rx_timeout_flag = 1'b1;
            next_r.rx_discard = 1'b1;
        end

        // A timeout answers the command of its cycle with neither cmd_accept nor cmd_reject and drops a status answer not yet in LSS_ST_SEND_SECONDARY.
        if (cmd_valid && !timeout_hit) begin
            if (lss_needs_id(cmd_code) && !verified_now) begin
                next_r.cmd_reject = 1'b1;
            end else begin
                next_r.cmd_accept = 1'b1;
            end
        end

        // The primary byte is latched with the command, then both bytes go out back to back.
        // A read that arrives while an answer runs is accepted but does not restart it.
        case (r.state)
            LSS_ST_IDLE: begin
                if (is_read && !timeout_hit) begin
                    next_r.primary_latch = primary_status;
                    next_r.state = LSS_ST_SEND_PRIMARY;
                end
            end
            LSS_ST_SEND_PRIMARY: begin
                next_r.tx_valid = 1'b1;
                next_r.tx_data = r.primary_latch;
                next_r.state = timeout_hit ? LSS_ST_IDLE : LSS_ST_SEND_SECONDARY;
            end
            LSS_ST_SEND_SECONDARY: begin
                next_r.tx_valid = 1'b1;
                next_r.tx_data = lss_compose(r);
                next_r.state = LSS_ST_IDLE;
            end
            default: begin
                next_r.state = LSS_ST_IDLE;
            end
        endcase
        // A secondary byte already on its way is finished rather than cut, so the
        // programmer never sees half an answer; earlier stages are simply dropped.
        if (timeout_hit && (r.state != LSS_ST_SEND_SECONDARY)) begin
            next_r.state = LSS_ST_IDLE;
            next_r.tx_valid = 1'b0;
        end

        // The view follows the next flags so that it moves in the same cycle as the flags.
        next_r.status_view = lss_compose(next_r);
        next_r.id_verified = {next_r.id_result_high_bit, next_r.id_result_low_bit} ==
                             LSS_ID_VERIFIED;

        // power_on wins over reset: of the two, only power_on zeroes the flags.
        if (power_on) begin
            next_r = '0;
            next_r.state = LSS_ST_IDLE;
            next_r.status_view = LSS_POWER_ON_VALUE;
        end else if (reset) begin
            // Flags survive reset; only the handler side returns to its start.
            next_r.state = LSS_ST_IDLE;
            next_r.primary_latch = 8'h00;
            next_r.tx_valid = 1'b0;
            next_r.tx_data = 8'h00;
            next_r.cmd_accept = 1'b0;
            next_r.cmd_reject = 1'b0;
            next_r.rx_discard = 1'b0;
            next_r.boot_update_done_flag = r.boot_update_done_flag;
            next_r.checksum_match_flag = r.checksum_match_flag;
            next_r.id_result_high_bit = r.id_result_high_bit;
            next_r.id_result_low_bit = r.id_result_low_bit;
            next_r.rx_timeout_flag = r.rx_timeout_flag;
            next_r.status_view = lss_compose(r);
            next_r.id_verified = {r.id_result_high_bit, r.id_result_low_bit} ==
                                 LSS_ID_VERIFIED;
        end
    end

    // No reset term here: power_on and reset are both folded into next_r above.
    always_ff @(posedge clk_sys) begin
        r <= next_r;
    end

    ////////////////////////////////////////////////////////////////////////////////

    // Every output is a field of r, so each one comes straight from a flip-flop.
    assign tx_valid = r.tx_valid;
    assign tx_data = r.tx_data;
    assign cmd_accept = r.cmd_accept;
    assign cmd_reject = r.cmd_reject;
    assign rx_discard = r.rx_discard;
    assign loader_status_secondary = r.status_view;
    assign id_verified = r.id_verified;

endmodule // lss_status_reg

// >>> lss_status_reg_asserts.sv
// Purpose: Port-level assertions for the secondary loader status register.
// Assumes: power_on and reset quiet the handler checks.
// Notes: Bound onto every lss_status_reg instance.
`timescale 1ns/1ns
module lss_status_reg_asserts import lss_pkg::*; (
    // Clock, resets and commands
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic power_on,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    // Events
    input wire logic rx_active,
    input wire logic rx_timeout,
    input wire logic download_end,
    input wire logic checksum_ok,
    input wire logic id_check_end,
    input wire logic id_match,
    input wire logic [7:0] primary_status,
    // Outputs
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic cmd_accept,
    input wire logic cmd_reject,
    input wire logic rx_discard,
    input wire logic [7:0] loader_status_secondary,
    input wire logic id_verified
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset || power_on);
    logic [7:0] st;
    logic tmo;
    logic prot;
    assign st = loader_status_secondary;
    assign tmo = rx_timeout && rx_active;
    assign prot = cmd_code inside {LSS_CMD_PAGE_READ, LSS_CMD_PAGE_PROGRAM,
        LSS_CMD_ERASE_ALL, LSS_CMD_DOWNLOAD};
    sequence read_go;
        cmd_valid && cmd_code == LSS_CMD_READ_STATUS && !tx_valid && !cmd_accept
            && !rx_active ##1 !rx_active [*2];
    endsequence
    rsv_zero_a: assert property (
        st[6:5] == 2'h0 && !st[0]) else $error("reserved bit set");
    id_code_a: assert property (
        id_check_end |=> st[3:2] == ($past(id_match) ? LSS_ID_VERIFIED : LSS_ID_MISMATCH))
        else $error("id result wrong");
    id_rsv_a: assert property (
        st[3:2] != 2'h2) else $error("reserved id code");
    refuse_a: assert property (
        cmd_valid && prot && !id_verified && !tmo |=> cmd_reject && !cmd_accept)
        else $error("protected command not refused");
    tmo_flag_a: assert property (
        tmo |=> st[1] && rx_discard) else $error("timeout not flagged");
    boot_done_a: assert property (
        download_end |=> st[7] && st[4] == $past(checksum_ok))
        else $error("download flags wrong");
    read_pair_a: assert property (
        read_go |-> tx_valid && tx_data == $past(primary_status, 2)
            ##1 tx_valid && tx_data == $past(st)) else $error("read answer wrong");
    clear_all_a: assert property (
        cmd_valid && cmd_code == LSS_CMD_CLEAR_STATUS && !tmo && !download_end
            && !id_check_end |=> cmd_accept && st == LSS_POWER_ON_VALUE)
        else $error("clear failed");
    reset_keep_a: assert property (disable iff (power_on)
        reset && !download_end && !id_check_end && !tmo |=> st == $past(st))
        else $error("reset changed flags");
    pon_zero_a: assert property (disable iff (1'b0)
        power_on |=> st == LSS_POWER_ON_VALUE && !tx_valid) else $error("power-on not zero");
    read_c: cover property (read_go);
    clear_c: cover property (cmd_valid && cmd_code == LSS_CMD_CLEAR_STATUS);
    tmo_c: cover property (tmo);
    abort_c: cover property (tmo && cmd_accept);
endmodule // lss_status_reg_asserts
bind lss_status_reg lss_status_reg_asserts chk_i (
    .clk_sys(clk_sys),
    .reset(reset),
    .power_on(power_on),
    .cmd_valid(cmd_valid),
    .cmd_code(cmd_code),
    .rx_active(rx_active),
    .rx_timeout(rx_timeout),
    .download_end(download_end),
    .checksum_ok(checksum_ok),
    .id_check_end(id_check_end),
    .id_match(id_match),
    .primary_status(primary_status),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .cmd_accept(cmd_accept),
    .cmd_reject(cmd_reject),
    .rx_discard(rx_discard),
    .loader_status_secondary(loader_status_secondary),
    .id_verified(id_verified)
);

// >>> lss_prog_model.sv
// Purpose: Serial programmer model issuing command bytes and collecting answers.
// Assumes: Commands are driven at the falling edge.
// Notes: The code lines carry garbage while no command is offered.
`timescale 1ns/1ns
module lss_prog_model import lss_pkg::*; (
    // Clock and answer stream
    input wire logic clk_sys,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    // Command bytes
    output logic cmd_valid,
    output logic [7:0] cmd_code
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
    end
    task automatic send(input logic [7:0] code);
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd_code = code;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        cmd_code = ~code;
    endtask
    task automatic read_status(output logic [7:0] p, output logic [7:0] s, output logic got);
        got = 1'b0;
        send(LSS_CMD_READ_STATUS);
        for (int i = 0; i < 4 && !got; i++) begin
            @(negedge clk_sys);
            got = tx_valid;
        end
        p = tx_data;
        @(negedge clk_sys);
        got = got && tx_valid;
        s = tx_data;
    endtask
endmodule // lss_prog_model

// >>> test_lss_status_reg.sv
// Purpose: Self-checking bench for the secondary loader status register.
// Assumes: Inputs change at the falling edge.
// Notes: Outputs are sampled one falling edge after the taking edge.
`timescale 1ns/1ns
module test_lss_status_reg;
    import lss_pkg::*;
    logic clk_sys, reset, power_on, rx_active, rx_timeout, download_end, checksum_ok;
    logic id_check_end, id_match, tx_valid, cmd_accept, cmd_reject, rx_discard;
    logic id_verified, cmd_valid, got;
    logic [7:0] cmd_code, primary_status, tx_data, loader_status_secondary, p, s;
    logic [7:0] prot [4] = '{LSS_CMD_PAGE_READ, LSS_CMD_PAGE_PROGRAM, LSS_CMD_ERASE_ALL,
        LSS_CMD_DOWNLOAD};
    int err_count = 0;
    int n_checks = 0;
    lss_status_reg dut (
        .clk_sys(clk_sys),
        .reset(reset),
        .power_on(power_on),
        .cmd_valid(cmd_valid),
        .cmd_code(cmd_code),
        .rx_active(rx_active),
        .rx_timeout(rx_timeout),
        .download_end(download_end),
        .checksum_ok(checksum_ok),
        .id_check_end(id_check_end),
        .id_match(id_match),
        .primary_status(primary_status),
        .tx_valid(tx_valid),
        .tx_data(tx_data),
        .cmd_accept(cmd_accept),
        .cmd_reject(cmd_reject),
        .rx_discard(rx_discard),
        .loader_status_secondary(loader_status_secondary),
        .id_verified(id_verified)
    );
    lss_prog_model prog (
        .clk_sys(clk_sys),
        .tx_valid(tx_valid),
        .tx_data(tx_data),
        .cmd_valid(cmd_valid),
        .cmd_code(cmd_code)
    );
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic pulse(ref logic sig);
        @(negedge clk_sys);
        sig = 1'b1;
        @(negedge clk_sys);
        sig = 1'b0;
    endtask
    task automatic print_verdict;
        $display("errors %0d checks %0d", err_count, n_checks);
        if (err_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        {reset, power_on, rx_active, rx_timeout, download_end} = 5'h18;
        {checksum_ok, id_check_end, id_match} = 3'h0;
        primary_status = 8'h80;
        repeat (8) @(negedge clk_sys);
        {reset, power_on} = 2'h0;
        chk(loader_status_secondary, 8'h00);
        prog.send(LSS_CMD_VERSION);
        chk({6'h00, cmd_accept, cmd_reject}, 8'h02);
        foreach (prot[i]) begin
            prog.send(prot[i]);
            chk({6'h00, cmd_accept, cmd_reject}, 8'h01);
        end
        pulse(id_check_end);
        chk(loader_status_secondary, 8'h04);
        chk({7'h00, id_verified}, 8'h00);
        id_match = 1'b1;
        pulse(id_check_end);
        chk(loader_status_secondary, 8'h0C);
        chk({7'h00, id_verified}, 8'h01);
        foreach (prot[i]) begin
            prog.send(prot[i]);
            chk({6'h00, cmd_accept, cmd_reject}, 8'h02);
        end
        pulse(download_end);
        chk(loader_status_secondary, 8'h8C);
        checksum_ok = 1'b1;
        pulse(download_end);
        chk(loader_status_secondary, 8'h9C);
        rx_active = 1'b1;
        pulse(rx_timeout);
        chk({rx_discard, loader_status_secondary[6:0]}, 8'h9E);
        rx_active = 1'b0;
        primary_status = 8'hA5;
        prog.read_status(p, s, got);
        chk({7'h00, got}, 8'h01);
        chk(p, 8'hA5);
        chk(s, 8'h9E);
        reset = 1'b1;
        repeat (8) @(negedge clk_sys);
        reset = 1'b0;
        chk(loader_status_secondary, 8'h9E);
        chk({7'h00, id_verified}, 8'h01);
        rx_active = 1'b1;
        prog.send(LSS_CMD_READ_STATUS);
        rx_timeout = 1'b1;
        @(negedge clk_sys);
        {rx_active, rx_timeout} = 2'h0;
        chk({6'h00, tx_valid, rx_discard}, 8'h01);
        @(negedge clk_sys);
        chk({7'h00, tx_valid}, 8'h00);
        chk(loader_status_secondary, 8'h9E);
        prog.send(LSS_CMD_CLEAR_STATUS);
        chk(loader_status_secondary, 8'h00);
        chk({7'h00, id_verified}, 8'h00);
        pulse(download_end);
        chk(loader_status_secondary, 8'h90);
        power_on = 1'b1;
        @(negedge clk_sys);
        power_on = 1'b0;
        chk(loader_status_secondary, 8'h00);
        print_verdict();
    end
endmodule // test_lss_status_reg
